// ---- design/dbfa_pkg.sv ----
// Constants and types shared by the boot and flash access decoder.
// How it works
// R1: Primary processor strapped to boot from flash.
// R2: Secondary processor boots only via host port.
// R3: Boot enable bit low holds off primary boot.
// R4: Boot reads first kilobyte at flash base.
// R5: Loader copies upper half page itself.
// R6: Whole boot loader fits flash page zero.
// R7: Users leave flash reading page zero.
// R8: Loader runs its setup steps in order.
// R9: Chip select zero decodes three control registers.
// R10: Flash data, address and command ports decoded.
// R11: Commands and addresses written to latch ports.
// R12: Seek page first, then read bytes sequentially.
// R13: Page is 2 KB, block is 128 KB.
// R14: Byte-wide flash on chip selects one, two.
// R15: Secondary program sets its own port timing.
// R16: Flash chip enable only in flash windows.
package dbfa_pkg;

   // ---------------------------------------------------------------
   // Memory map of the second memory port
   // ---------------------------------------------------------------
   localparam int OFF_W = 17;
   localparam logic [31:0] CS0_BASE = 32'h6000_0000;
   localparam logic [31:0] CS1_BASE = 32'h6400_0000;
   localparam logic [31:0] CS3_BASE = 32'h6C00_0000;
   localparam logic [31:0] ADDR_FPGA_CFG_CTL = 32'h6000_0001;
   localparam logic [31:0] ADDR_FLASH_CTL = 32'h6000_0004;
   localparam logic [31:0] ADDR_FPGA_CFG_DATA = 32'h6000_8000;
   localparam logic [31:0] ADDR_FLASH_DATA = 32'h6400_0000;
   localparam logic [31:0] ADDR_FLASH_ALE = 32'h6400_8000;
   localparam logic [31:0] ADDR_FLASH_CLE = 32'h6401_0000;
   localparam logic [OFF_W-1:0] OFF_FPGA_CFG_CTL = OFF_W'(ADDR_FPGA_CFG_CTL - CS0_BASE);
   localparam logic [OFF_W-1:0] OFF_FLASH_CTL = OFF_W'(ADDR_FLASH_CTL - CS0_BASE);
   localparam logic [OFF_W-1:0] OFF_FPGA_CFG_DATA = OFF_W'(ADDR_FPGA_CFG_DATA - CS0_BASE);
   localparam logic [OFF_W-1:0] OFF_FLASH_DATA = OFF_W'(ADDR_FLASH_DATA - CS1_BASE);
   localparam logic [OFF_W-1:0] OFF_FLASH_ALE = OFF_W'(ADDR_FLASH_ALE - CS1_BASE);
   localparam logic [OFF_W-1:0] OFF_FLASH_CLE = OFF_W'(ADDR_FLASH_CLE - CS1_BASE);

   // ---------------------------------------------------------------
   // Register fields and reset values
   // ---------------------------------------------------------------
   localparam int CFG_PROG_BIT = 0;
   localparam int CFG_INIT_BIT = 6;
   localparam int CFG_DONE_BIT = 7;
   localparam logic [7:0] CFG_CTL_RESET = 8'h00;
   localparam int FL_BOOT_EN_BIT = 0;
   localparam int FL_WP_N_BIT = 1;
   localparam int FL_PAGE_END_BIT = 5;
   localparam int FL_READY_BIT = 7;
   localparam logic [7:0] FLASH_CTL_RESET = 8'h00;
   localparam logic BOOT_EN_RESET = 1'b0;

   // ---------------------------------------------------------------
   // Boot straps and flash geometry
   // ---------------------------------------------------------------
   localparam logic [1:0] BOOT_MODE_FLASH = 2'h2;
   localparam logic [1:0] BOOT_MODE_HOST = 2'h1;
   localparam int BOOT_COPY_BYTES = 1024;
   localparam int PAGE_BYTES = 2048;
   localparam int BLOCK_BYTES = 131072;
   localparam int PAGES_PER_BLOCK = BLOCK_BYTES / PAGE_BYTES;
   localparam int COL_W = 12;

   // ---------------------------------------------------------------
   // Timing
   // ---------------------------------------------------------------
   localparam int CLK_MHZ = 200;
   localparam int NAND_PULSE_NS = 25;
   localparam int NAND_PULSE_CYC = (NAND_PULSE_NS * CLK_MHZ + 999) / 1000;
   localparam int CFG_FIFO_DEPTH = 4;

   typedef enum logic [1:0] {
      ST_IDLE,
      ST_FIFO,
      ST_NAND,
      ST_DONE
   } dbfa_state_type;

endpackage

// ---- design/dbfa_top.sv ----
// Boot and flash access decoder with its configuration data FIFO.
`timescale 1ns/1ps

// -------------------------------------------------------------------
// Small synchronous FIFO
// -------------------------------------------------------------------
module dbfa_fifo #(
   parameter int WIDTH = 32,
   parameter int DEPTH = 4
) (
   // Clock and reset
   input wire logic clk_sys_i,
   input wire logic resetn_i,
   // Fill side
   input wire logic [WIDTH-1:0] in_data_i,
   input wire logic in_valid_i,
   output logic in_ready_o,
   // Drain side
   output logic [WIDTH-1:0] out_data_o,
   output logic out_valid_o,
   input wire logic out_ready_i
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wr_ptr_reg;
   logic [AW-1:0] rd_ptr_reg;
   logic [AW:0] count_reg;
   wire push = in_valid_i && in_ready_o;
   wire pop = out_valid_o && out_ready_i;

   assign in_ready_o = count_reg != (AW+1)'(DEPTH);
   assign out_valid_o = count_reg != '0;
   assign out_data_o = mem[rd_ptr_reg];

   always_ff @(posedge clk_sys_i) begin
      if (push) begin
         mem[wr_ptr_reg] <= in_data_i;
      end
   end

   always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         count_reg <= '0;
      end else begin
         if (push) begin
            wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH - 1)) ? '0 : wr_ptr_reg + 1'b1;
         end
         if (pop) begin
            rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH - 1)) ? '0 : rd_ptr_reg + 1'b1;
         end
         count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule

// -------------------------------------------------------------------
// Board control decoder on the second memory port
// -------------------------------------------------------------------
module dbfa_top #(
   parameter logic BOOT_EN_DEFAULT = dbfa_pkg::BOOT_EN_RESET
) (
   // Clock and reset
   input wire logic clk_sys_i,
   input wire logic resetn_i,
   // Second memory port of the primary processor
   input wire logic [3:0] mem_ce_n_i,
   input wire logic mem_are_n_i,
   input wire logic mem_awe_n_i,
   input wire logic [dbfa_pkg::OFF_W-1:0] mem_addr_i,
   input wire logic [31:0] mem_data_i,
   output logic [31:0] mem_data_o,
   output logic mem_data_oe_o,
   output logic mem_ardy_o,
   // Boot straps and boot hold
   output logic [1:0] primary_boot_mode_o,
   output logic [1:0] secondary_boot_mode_o,
   output logic primary_boot_hold_o,
   // Secondary processor host port select
   output logic host_port_cs_n_o,
   // NAND flash pins
   output logic nand_ce_n_o,
   output logic nand_cle_o,
   output logic nand_ale_o,
   output logic nand_we_n_o,
   output logic nand_re_n_o,
   output logic nand_wp_n_o,
   input wire logic nand_rb_n_i,
   input wire logic [7:0] nand_io_i,
   output logic [7:0] nand_io_o,
   output logic nand_io_oe_o,
   // FPGA configuration port
   output logic fpga_cfg_prog_o,
   output logic [31:0] fpga_cfg_data_o,
   output logic fpga_cfg_valid_o,
   input wire logic fpga_cfg_ready_i,
   input wire logic fpga_cfg_done_i,
   input wire logic fpga_cfg_init_n_i
);
   localparam int SW = 4 + 2 + dbfa_pkg::OFF_W + 32 + 3 + 8;
   localparam logic [3:0] PULSE_CYC = 4'(dbfa_pkg::NAND_PULSE_CYC);

   // ---------------------------------------------------------------
   // Pin synchronisers
   // ---------------------------------------------------------------
   // A bit moves once stages two and three agree, so one glitch is lost.
   logic [SW-1:0] sync1_reg;
   logic [SW-1:0] sync2_reg;
   logic [SW-1:0] sync3_reg;
   logic [SW-1:0] pin_reg;
   wire [SW-1:0] raw_pins = {mem_ce_n_i, mem_are_n_i, mem_awe_n_i, mem_addr_i, mem_data_i,
                             nand_rb_n_i, fpga_cfg_done_i, fpga_cfg_init_n_i, nand_io_i};
   wire [SW-1:0] agree = ~(sync2_reg ^ sync3_reg);
   wire [SW-1:0] pin_next = (agree & sync3_reg) | (~agree & pin_reg);

   always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         sync1_reg <= {{6{1'b1}}, {(SW-6){1'b0}}};
         sync2_reg <= {{6{1'b1}}, {(SW-6){1'b0}}};
         sync3_reg <= {{6{1'b1}}, {(SW-6){1'b0}}};
         pin_reg <= {{6{1'b1}}, {(SW-6){1'b0}}};
      end else begin
         sync1_reg <= raw_pins;
         sync2_reg <= sync1_reg;
         sync3_reg <= sync2_reg;
         pin_reg <= pin_next;
      end
   end

   wire [3:0] ce_n = pin_reg[SW-1 -: 4];
   wire are_n = pin_reg[SW-5];
   wire awe_n = pin_reg[SW-6];
   wire [dbfa_pkg::OFF_W-1:0] addr = pin_reg[SW-7 -: dbfa_pkg::OFF_W];
   wire [31:0] wdata = pin_reg[42 -: 32];
   wire rb_n = pin_reg[10];
   wire cfg_done = pin_reg[9];
   wire cfg_init_n = pin_reg[8];
   wire [7:0] nand_rd = pin_reg[7:0];

   // ---------------------------------------------------------------
   // Address decode
   // ---------------------------------------------------------------
   dbfa_pkg::dbfa_state_type state_reg;
   dbfa_pkg::dbfa_state_type state_next;
   logic [3:0] cnt_reg;
   logic [7:0] cfg_ctl_reg;
   logic [7:0] flash_ctl_reg;
   logic [dbfa_pkg::COL_W-1:0] col_reg;
   logic [31:0] rdata_reg;
   logic fifo_in_ready;
   logic [31:0] fifo_out_data;
   logic fifo_out_valid;

   wire rd_act = !are_n;
   wire wr_act = !awe_n;
   wire req = rd_act || wr_act;
   wire sel_ctl = !ce_n[0];                                       // [R9]
   wire sel_flash = !ce_n[1] || !ce_n[2];                         // [R14]
   wire sel_host = !ce_n[3];                                      // [R2]
   wire hit_cfg_ctl = sel_ctl && addr == dbfa_pkg::OFF_FPGA_CFG_CTL;     // [R9]
   wire hit_flash_ctl = sel_ctl && addr == dbfa_pkg::OFF_FLASH_CTL;      // [R9]
   wire hit_cfg_data = sel_ctl && addr == dbfa_pkg::OFF_FPGA_CFG_DATA;   // [R9]
   wire is_ale = addr == dbfa_pkg::OFF_FLASH_ALE;                 // [R10]
   wire is_cle = addr == dbfa_pkg::OFF_FLASH_CLE;                 // [R10]
   wire is_data = !is_ale && !is_cle;                             // [R10]
   wire start = state_reg == dbfa_pkg::ST_IDLE && req && (sel_ctl || sel_flash);
   wire in_nand = state_reg == dbfa_pkg::ST_NAND;
   wire nand_last = in_nand && cnt_reg == '0;
   wire fifo_push = state_reg == dbfa_pkg::ST_FIFO;
   wire reg_we = start && wr_act && sel_ctl;
   wire boot_en = flash_ctl_reg[dbfa_pkg::FL_BOOT_EN_BIT];
   wire page_end = col_reg == dbfa_pkg::COL_W'(dbfa_pkg::PAGE_BYTES);

   // Unmapped control offsets read as zero; the status bits are live.
   wire [7:0] cfg_ctl_rd = {cfg_done, cfg_init_n, 5'h00, cfg_ctl_reg[dbfa_pkg::CFG_PROG_BIT]};
   wire [7:0] flash_ctl_rd = {rb_n, 1'b0, page_end, 3'h0, flash_ctl_reg[1:0]};
   wire [31:0] ctl_rdata = hit_cfg_ctl ? {24'h00_0000, cfg_ctl_rd} :
                           hit_flash_ctl ? {24'h00_0000, flash_ctl_rd} : 32'h0000_0000;

   // ---------------------------------------------------------------
   // Access sequencer
   // ---------------------------------------------------------------
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         dbfa_pkg::ST_IDLE: begin
            if (start && sel_flash) begin
               state_next = dbfa_pkg::ST_NAND;
            end else if (start && wr_act && hit_cfg_data) begin
               state_next = dbfa_pkg::ST_FIFO;
            end else if (start) begin
               state_next = dbfa_pkg::ST_DONE;
            end
         end
         dbfa_pkg::ST_FIFO: begin
            // A full FIFO keeps ready low, stalling the processor's write.
            if (fifo_in_ready) begin
               state_next = dbfa_pkg::ST_DONE;
            end
         end
         dbfa_pkg::ST_NAND: begin
            if (nand_last) begin
               state_next = dbfa_pkg::ST_DONE;
            end
         end
         dbfa_pkg::ST_DONE: begin
            if (!req) begin
               state_next = dbfa_pkg::ST_IDLE;
            end
         end
         default: begin
            state_next = dbfa_pkg::ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         state_reg <= dbfa_pkg::ST_IDLE;
         cnt_reg <= '0;
      end else begin
         state_reg <= state_next;
         cnt_reg <= start ? PULSE_CYC : (in_nand && cnt_reg != '0) ? cnt_reg - 1'b1 : cnt_reg;
      end
   end

   // ---------------------------------------------------------------
   // Control registers
   // ---------------------------------------------------------------
   always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         cfg_ctl_reg <= dbfa_pkg::CFG_CTL_RESET;
         flash_ctl_reg <= dbfa_pkg::FLASH_CTL_RESET | {7'h00, BOOT_EN_DEFAULT};   // [R3]
      end else begin
         if (reg_we && hit_cfg_ctl) begin
            cfg_ctl_reg <= wdata[7:0];                               // [R9]
         end
         if (reg_we && hit_flash_ctl) begin
            flash_ctl_reg <= {6'h00, wdata[1:0]};                    // [R9]
         end
      end
   end

   // A command restarts the page; reads stop at its end so a run-off shows.
   always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         col_reg <= '0;
      end else if (nand_last && wr_act && is_cle) begin
         col_reg <= '0;                                              // [R12]
      end else if (nand_last && rd_act && is_data && !page_end) begin
         col_reg <= col_reg + 1'b1;                                  // [R13]
      end
   end

   always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         rdata_reg <= '0;
      end else if (start && sel_ctl) begin
         rdata_reg <= ctl_rdata;
      end else if (nand_last) begin
         rdata_reg <= {24'h00_0000, nand_rd};                        // [R4]
      end
   end

   // ---------------------------------------------------------------
   // Configuration data path
   // ---------------------------------------------------------------
   dbfa_fifo #(
      .WIDTH(32),
      .DEPTH(dbfa_pkg::CFG_FIFO_DEPTH)
   ) u_cfg_fifo (
      .clk_sys_i(clk_sys_i),
      .resetn_i(resetn_i),
      .in_data_i(wdata),
      .in_valid_i(fifo_push),
      .in_ready_o(fifo_in_ready),
      .out_data_o(fifo_out_data),
      .out_valid_o(fifo_out_valid),
      .out_ready_i(!fpga_cfg_valid_o || fpga_cfg_ready_i)
   );

   always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         fpga_cfg_data_o <= '0;
         fpga_cfg_valid_o <= 1'b0;
      end else if (!fpga_cfg_valid_o || fpga_cfg_ready_i) begin
         fpga_cfg_data_o <= fifo_out_data;
         fpga_cfg_valid_o <= fifo_out_valid;
      end
   end

   // ---------------------------------------------------------------
   // Output registers
   // ---------------------------------------------------------------
   // The NAND cycle after the pulse keeps latches and data steady as hold time.
   wire pulse = in_nand && cnt_reg != '0;

   always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         mem_data_o <= '0;
         mem_data_oe_o <= 1'b0;
         mem_ardy_o <= 1'b0;
         nand_ce_n_o <= 1'b1;
         nand_cle_o <= 1'b0;
         nand_ale_o <= 1'b0;
         nand_we_n_o <= 1'b1;
         nand_re_n_o <= 1'b1;
         nand_io_o <= '0;
         nand_io_oe_o <= 1'b0;
      end else begin
         mem_data_o <= rdata_reg;
         mem_data_oe_o <= rd_act && (sel_ctl || sel_flash) && state_reg == dbfa_pkg::ST_DONE;
         mem_ardy_o <= state_reg == dbfa_pkg::ST_DONE || sel_host;
         nand_ce_n_o <= !(in_nand && sel_flash);                     // [R16]
         nand_cle_o <= in_nand && is_cle;                            // [R10]
         nand_ale_o <= in_nand && is_ale;                            // [R10]
         nand_we_n_o <= !(pulse && wr_act);
         nand_re_n_o <= !(pulse && rd_act);
         nand_io_o <= wdata[7:0];                                    // [R14]
         nand_io_oe_o <= in_nand && wr_act;
      end
   end

   always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         primary_boot_mode_o <= dbfa_pkg::BOOT_MODE_FLASH;
         secondary_boot_mode_o <= dbfa_pkg::BOOT_MODE_HOST;
         primary_boot_hold_o <= 1'b1;
         host_port_cs_n_o <= 1'b1;
         nand_wp_n_o <= 1'b0;
         fpga_cfg_prog_o <= 1'b0;
      end else begin
         primary_boot_mode_o <= dbfa_pkg::BOOT_MODE_FLASH;           // [R1]
         secondary_boot_mode_o <= dbfa_pkg::BOOT_MODE_HOST;          // [R2]
         primary_boot_hold_o <= !boot_en;                            // [R3]
         host_port_cs_n_o <= !sel_host;                              // [R2]
         nand_wp_n_o <= flash_ctl_reg[dbfa_pkg::FL_WP_N_BIT];
         fpga_cfg_prog_o <= cfg_ctl_reg[dbfa_pkg::CFG_PROG_BIT];
      end
   end
endmodule

// ---- sim/dbfa_top_properties.sv ----
// Concurrent checks on the ports of the boot and flash access decoder.
`timescale 1ns/1ps

// ---------------------------------------------------------------
// Port checker
// ---------------------------------------------------------------
module dbfa_top_properties (
   // Clock and reset
   input wire logic clk_sys_i,
   input wire logic resetn_i,
   // Memory port
   input wire logic [3:0] mem_ce_n_i,
   input wire logic mem_ardy_o,
   input wire logic mem_data_oe_o,
   // Straps and host port
   input wire logic [1:0] primary_boot_mode_o,
   input wire logic [1:0] secondary_boot_mode_o,
   input wire logic host_port_cs_n_o,
   // Flash pins
   input wire logic nand_ce_n_o,
   input wire logic nand_cle_o,
   input wire logic nand_ale_o,
   input wire logic nand_we_n_o,
   input wire logic nand_re_n_o,
   input wire logic nand_io_oe_o
);
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (!resetn_i);

   a_boot_straps: assert property (
      primary_boot_mode_o == dbfa_pkg::BOOT_MODE_FLASH &&
      secondary_boot_mode_o == dbfa_pkg::BOOT_MODE_HOST) else $error("boot straps wrong");
   a_flash_window: assert property (
      !nand_ce_n_o |-> (!mem_ce_n_i[1] || !mem_ce_n_i[2])) else $error("flash enabled outside");
   a_host_no_flash: assert property (
      !host_port_cs_n_o |-> nand_ce_n_o) else $error("flash in host region");
   a_latch_exclusive: assert property (
      !(nand_cle_o && nand_ale_o)) else $error("both latches");
   a_latch_needs_ce: assert property (
      (nand_cle_o || nand_ale_o) |-> !nand_ce_n_o) else $error("latch without chip enable");
   a_write_pulse: assert property (
      $fell(nand_we_n_o) |-> !nand_we_n_o [*5] ##1 nand_we_n_o) else $error("we pulse");
   a_read_pulse: assert property (
      $fell(nand_re_n_o) |-> !nand_re_n_o [*5] ##1 nand_re_n_o) else $error("re pulse");
   a_no_drive_read: assert property (
      nand_io_oe_o |-> nand_re_n_o && !mem_data_oe_o) else $error("bus clash");
   a_ready_holds: assert property (
      $rose(mem_ardy_o) |-> mem_ardy_o [*4]) else $error("ready short");

   c_command: cover property (nand_cle_o && $rose(nand_we_n_o));
   c_read: cover property ($rose(nand_re_n_o) && !nand_ce_n_o);
   c_host: cover property (!host_port_cs_n_o && mem_ardy_o);
endmodule

bind dbfa_top dbfa_top_properties u_props (
   .clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .mem_ce_n_i(mem_ce_n_i),
   .mem_ardy_o(mem_ardy_o), .mem_data_oe_o(mem_data_oe_o),
   .primary_boot_mode_o(primary_boot_mode_o), .secondary_boot_mode_o(secondary_boot_mode_o),
   .host_port_cs_n_o(host_port_cs_n_o), .nand_ce_n_o(nand_ce_n_o), .nand_cle_o(nand_cle_o),
   .nand_ale_o(nand_ale_o), .nand_we_n_o(nand_we_n_o), .nand_re_n_o(nand_re_n_o),
   .nand_io_oe_o(nand_io_oe_o)
);

// ---- sim/dbfa_far_model.sv ----
// Far-side model: byte-wide flash device and configuration stream sink.
`timescale 1ns/1ps

module dbfa_far_model (
   // Clock
   input wire logic clk_sys_i,
   // Flash pins from the decoder
   input wire logic nand_ce_n_i,
   input wire logic nand_cle_i,
   input wire logic nand_ale_i,
   input wire logic nand_we_n_i,
   input wire logic nand_re_n_i,
   input wire logic [7:0] nand_io_i,
   output logic [7:0] nand_io_o,
   output logic nand_rb_n_o,
   // Configuration stream
   input wire logic [31:0] cfg_data_i,
   input wire logic cfg_valid_i,
   input wire logic stall_i,
   output logic cfg_ready_o
);
   logic [7:0] cmd_reg = 8'hFF;
   logic [7:0] addr_reg = 8'hFF;
   logic [7:0] last_reg = 8'h00;
   logic [11:0] col_reg = 12'h000;
   logic we_q = 1'b1;
   logic re_q = 1'b1;
   logic [31:0] cfg_words [0:7];
   int cfg_count = 0;

   assign nand_rb_n_o = 1'b1;
   assign cfg_ready_o = !stall_i;
   // A released bus shows its last value inverted.
   assign nand_io_o = (!nand_ce_n_i && !nand_re_n_i) ? (8'hA5 ^ col_reg[7:0]) : ~last_reg;

   always @(posedge clk_sys_i) begin
      last_reg <= nand_io_o;
      we_q <= nand_we_n_i;
      re_q <= nand_re_n_i;
      if (nand_we_n_i && !we_q && nand_cle_i) begin
         cmd_reg <= nand_io_i;
         col_reg <= 12'h000;
      end
      if (nand_we_n_i && !we_q && nand_ale_i) addr_reg <= nand_io_i;
      if (nand_re_n_i && !re_q) col_reg <= col_reg + 12'h001;
      if (cfg_valid_i && !stall_i) begin
         cfg_words[cfg_count[2:0]] <= cfg_data_i;
         cfg_count <= cfg_count + 1;
      end
   end
endmodule

// ---- sim/dbfa_top_test.sv ----
// Self-checking bench for the boot and flash access decoder.
`timescale 1ns/1ps

module dbfa_top_test;
   localparam logic [3:0] CE0 = 4'hE;
   localparam logic [3:0] CE1 = 4'hD;
   localparam logic [3:0] CE2 = 4'hB;
   logic clk_sys_i = 1'b0;
   logic resetn_i = 1'b0;
   logic [3:0] mem_ce_n_i = 4'hF;
   logic mem_are_n_i = 1'b1;
   logic mem_awe_n_i = 1'b1;
   logic [dbfa_pkg::OFF_W-1:0] mem_addr_i = '0;
   logic [31:0] mem_data_i = '0;
   logic [31:0] mem_data_o, fpga_cfg_data_o, rd;
   logic [1:0] primary_boot_mode_o, secondary_boot_mode_o;
   logic mem_data_oe_o, mem_ardy_o, primary_boot_hold_o, host_port_cs_n_o, nand_ce_n_o;
   logic nand_cle_o, nand_ale_o, nand_we_n_o, nand_re_n_o, nand_wp_n_o, nand_rb_n_i;
   logic nand_io_oe_o, fpga_cfg_prog_o, fpga_cfg_valid_o, fpga_cfg_ready_i;
   logic [7:0] nand_io_i, nand_io_o;
   logic cfg_done = 1'b0;
   logic stall = 1'b0;
   logic host_seen, nand_seen;
   int failures = 0;
   int cmp_count = 0;

   dbfa_top u_dut (
      .clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .mem_ce_n_i(mem_ce_n_i),
      .mem_are_n_i(mem_are_n_i), .mem_awe_n_i(mem_awe_n_i), .mem_addr_i(mem_addr_i),
      .mem_data_i(mem_data_i), .mem_data_o(mem_data_o), .mem_data_oe_o(mem_data_oe_o),
      .mem_ardy_o(mem_ardy_o), .primary_boot_mode_o(primary_boot_mode_o),
      .secondary_boot_mode_o(secondary_boot_mode_o), .primary_boot_hold_o(primary_boot_hold_o),
      .host_port_cs_n_o(host_port_cs_n_o), .nand_ce_n_o(nand_ce_n_o), .nand_cle_o(nand_cle_o),
      .nand_ale_o(nand_ale_o), .nand_we_n_o(nand_we_n_o), .nand_re_n_o(nand_re_n_o),
      .nand_wp_n_o(nand_wp_n_o), .nand_rb_n_i(nand_rb_n_i), .nand_io_i(nand_io_i),
      .nand_io_o(nand_io_o), .nand_io_oe_o(nand_io_oe_o), .fpga_cfg_prog_o(fpga_cfg_prog_o),
      .fpga_cfg_data_o(fpga_cfg_data_o), .fpga_cfg_valid_o(fpga_cfg_valid_o),
      .fpga_cfg_ready_i(fpga_cfg_ready_i), .fpga_cfg_done_i(cfg_done),
      .fpga_cfg_init_n_i(resetn_i)
   );

   dbfa_far_model u_far (
      .clk_sys_i(clk_sys_i), .nand_ce_n_i(nand_ce_n_o), .nand_cle_i(nand_cle_o),
      .nand_ale_i(nand_ale_o), .nand_we_n_i(nand_we_n_o), .nand_re_n_i(nand_re_n_o),
      .nand_io_i(nand_io_o), .nand_io_o(nand_io_i), .nand_rb_n_o(nand_rb_n_i),
      .cfg_data_i(fpga_cfg_data_o), .cfg_valid_i(fpga_cfg_valid_o), .stall_i(stall),
      .cfg_ready_o(fpga_cfg_ready_i)
   );

   always #2.5 clk_sys_i = ~clk_sys_i;

   // ---------------------------------------------------------------
   // Shared tasks
   // ---------------------------------------------------------------
   task automatic bad(input string m);
      failures++;
      $display("BAD %0t %s", $time, m);
   endtask

   task automatic chk_bit(input logic a, input logic e, input string m);
      cmp_count++;
      if (a !== e) bad(m);
   endtask

   task automatic chk_word(input logic [31:0] a, input logic [31:0] e, input string m);
      cmp_count++;
      if (a !== e) bad(m);
   endtask

   // Strobes stand until ready is seen high.
   task automatic mem_acc(input logic [3:0] ce, input logic wr,
         input logic [dbfa_pkg::OFF_W-1:0] a, input logic [31:0] wd, output logic [31:0] d);
      int n;
      @(posedge clk_sys_i);
      #1;
      mem_ce_n_i = ce;
      mem_addr_i = a;
      mem_data_i = wd;
      mem_awe_n_i = !wr;
      mem_are_n_i = wr;
      n = 0;
      do begin
         @(posedge clk_sys_i);
         n++;
      end while (mem_ardy_o !== 1'b1 && n < 200);
      d = mem_data_o;
      host_seen = host_port_cs_n_o;
      nand_seen = nand_ce_n_o;
      if (n >= 200) bad("no ready");
      #1;
      mem_ce_n_i = 4'hF;
      mem_awe_n_i = 1'b1;
      mem_are_n_i = 1'b1;
      mem_addr_i = ~a;
      mem_data_i = ~wd;
      n = 0;
      while (mem_ardy_o !== 1'b0 && n < 50) begin
         @(posedge clk_sys_i);
         n++;
      end
   endtask

   task automatic close_out();
      $display("Comparisons %0d, mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask

   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   task automatic t_reset();
      chk_word(32'(primary_boot_mode_o), 32'(dbfa_pkg::BOOT_MODE_FLASH), "strap a");
      chk_word(32'(secondary_boot_mode_o), 32'(dbfa_pkg::BOOT_MODE_HOST), "strap b");
      chk_bit(primary_boot_hold_o, !dbfa_pkg::BOOT_EN_RESET, "hold");
      chk_bit(nand_ce_n_o, 1'b1, "flash idle");
   endtask

   task automatic t_regs();
      mem_acc(CE0, 1'b1, dbfa_pkg::OFF_FLASH_CTL, 32'h0000_0003, rd);
      chk_bit(primary_boot_hold_o, 1'b0, "boot enabled");
      chk_bit(nand_wp_n_o, 1'b1, "wp off");
      mem_acc(CE0, 1'b0, dbfa_pkg::OFF_FLASH_CTL, '0, rd);
      chk_word(rd & 32'h0000_0083, 32'h0000_0083, "flash ctl read");
      cfg_done = 1'b1;
      mem_acc(CE0, 1'b1, dbfa_pkg::OFF_FPGA_CFG_CTL, 32'h0000_0001, rd);
      chk_bit(fpga_cfg_prog_o, 1'b1, "prog pin");
      mem_acc(CE0, 1'b0, dbfa_pkg::OFF_FPGA_CFG_CTL, '0, rd);
      chk_word(rd & 32'h0000_00C1, 32'h0000_00C1, "cfg ctl read");
      mem_acc(CE0, 1'b0, 17'h0_0002, '0, rd);
      chk_word(rd, 32'h0000_0000, "unmapped");
      mem_acc(CE0, 1'b1, dbfa_pkg::OFF_FLASH_CTL, 32'h0000_0002, rd);
      chk_bit(primary_boot_hold_o, 1'b1, "boot held");
   endtask

   task automatic t_flash();
      mem_acc(CE1, 1'b1, dbfa_pkg::OFF_FLASH_CLE, 32'h0000_0030, rd);
      chk_word(32'(u_far.cmd_reg), 32'h0000_0030, "command byte");
      mem_acc(CE1, 1'b1, dbfa_pkg::OFF_FLASH_ALE, 32'h0000_005A, rd);
      chk_word(32'(u_far.addr_reg), 32'h0000_005A, "address byte");
      for (int i = 0; i < dbfa_pkg::PAGE_BYTES; i++) begin
         if (i == dbfa_pkg::PAGE_BYTES - 1) begin
            mem_acc(CE0, 1'b0, dbfa_pkg::OFF_FLASH_CTL, '0, rd);
            chk_bit(rd[dbfa_pkg::FL_PAGE_END_BIT], 1'b0, "page end early");
         end
         mem_acc(i[0] ? CE2 : CE1, 1'b0, dbfa_pkg::OFF_FLASH_DATA, '0, rd);
         chk_word(rd, 32'(8'hA5 ^ i[7:0]), "page byte");
      end
      mem_acc(CE0, 1'b0, dbfa_pkg::OFF_FLASH_CTL, '0, rd);
      chk_bit(rd[dbfa_pkg::FL_PAGE_END_BIT], 1'b1, "page end");
      mem_acc(CE1, 1'b1, dbfa_pkg::OFF_FLASH_CLE, 32'h0000_0000, rd);
   endtask

   task automatic t_host();
      mem_acc(4'h7, 1'b0, '0, '0, rd);
      chk_bit(host_seen, 1'b0, "host sel");
      chk_bit(nand_seen, 1'b1, "flash kept off");
   endtask

   task automatic t_fifo();
      stall = 1'b1;
      for (int i = 0; i < dbfa_pkg::CFG_FIFO_DEPTH + 1; i++)
         mem_acc(CE0, 1'b1, dbfa_pkg::OFF_FPGA_CFG_DATA, 32'hC0DE_0000 + 32'(i), rd);
      fork
         mem_acc(CE0, 1'b1, dbfa_pkg::OFF_FPGA_CFG_DATA, 32'hC0DE_0005, rd);
         begin
            repeat (40) @(posedge clk_sys_i);
            chk_bit(mem_ardy_o, 1'b0, "stall");
            chk_bit(fpga_cfg_valid_o, 1'b1, "stream offered");
            #1 stall = 1'b0;
         end
      join
      repeat (10) @(posedge clk_sys_i);
      chk_word(32'(u_far.cfg_count), 32'h0000_0006, "stream count");
      for (int i = 0; i < 6; i++)
         chk_word(u_far.cfg_words[i], 32'hC0DE_0000 + 32'(i), "stream order");
   endtask

   initial begin
      repeat (6) @(posedge clk_sys_i);
      #1 resetn_i = 1'b1;
      repeat (3) @(posedge clk_sys_i);
      t_reset();
      t_regs();
      t_host();
      t_fifo();
      t_flash();
      close_out();
   end

   // About twice the page walk.
   initial begin
      #500000;
      failures++;
      close_out();
   end
endmodule
